// File: logic/aac_pkg.sv
package aac_pkg;
    // ========================================================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] AAC_STATUS1_OFF = 8'h00;
    localparam logic [7:0] AAC_STATUS0_OFF = 8'h04;
    localparam logic [7:0] AAC_BUSC_OFF    = 8'h08;
    localparam logic [7:0] AAC_BUSD_OFF    = 8'h0c;
    localparam logic [7:0] AAC_IMM_OFF     = 8'h10;
    localparam logic [7:0] AAC_CMD_OFF     = 8'h14;
    localparam logic [7:0] AAC_ACC0_LO_OFF = 8'h18;
    localparam logic [7:0] AAC_ACC0_HI_OFF = 8'h1c;
    localparam logic [7:0] AAC_ACC1_LO_OFF = 8'h20;
    localparam logic [7:0] AAC_ACC1_HI_OFF = 8'h24;
    // ========================================================================
    // field positions
    localparam int AAC_FRAC_BIT  = 0;
    localparam int AAC_SAT_BIT   = 1;
    localparam int AAC_WIDE_BIT  = 2;
    localparam int AAC_SGNC_BIT  = 3;
    localparam int AAC_SGND_BIT  = 4;
    localparam int AAC_CARRY_BIT = 0;
    localparam int AAC_CMD_SRC   = 8;
    localparam int AAC_CMD_DST   = 9;
    // ========================================================================
    // widths and reset values
    localparam int AAC_ACC_W = 40;
    localparam int AAC_BUS_W = 16;
    localparam logic [4:0] AAC_STATUS1_RST = 5'h18;
    localparam logic       AAC_CARRY_RST   = 1'b0;
    // ========================================================================
    // commands
    typedef enum logic [4:0] {
        AAC_NOP      = 5'b00000, AAC_ADD_ACC = 5'b00001, AAC_ADD_MEM = 5'b00010,
        AAC_ADD_IMM  = 5'b00011, AAC_ADD_MM  = 5'b00100, AAC_ADD_MI  = 5'b00101,
        AAC_ADD_HI16 = 5'b00110, AAC_ADD_CY  = 5'b00111, AAC_ADD_DBL = 5'b01000,
        AAC_LD_DBL   = 5'b01001, AAC_SUB_ACC = 5'b01010, AAC_SUB_MEM = 5'b01011,
        AAC_SUB_IMM  = 5'b01100, AAC_SUB_MM  = 5'b01101, AAC_SUB_MI  = 5'b01110,
        AAC_SUB_HI16 = 5'b01111, AAC_SUB_BW  = 5'b10000, AAC_SUB_DBL = 5'b10001,
        AAC_MPY      = 5'b10010, AAC_SHL1    = 5'b10011, AAC_SHR1    = 5'b10100,
        AAC_CSET     = 5'b10101, AAC_CCLR    = 5'b10110
    } aac_op_type;
    typedef enum logic [2:0] {
        AAC_CM_NONE = 3'b000, AAC_CM_ALL = 3'b001, AAC_CM_SET = 3'b010,
        AAC_CM_CLR  = 3'b011, AAC_CM_ONE = 3'b100, AAC_CM_ZERO = 3'b101
    } aac_cmode_type;
endpackage

// File: logic/aac_mult.sv
`timescale 1ns/1ns
module aac_mult #(
    parameter int W = 16
) (
    // operands
    input  wire logic [W-1:0] mcand_i,
    input  wire logic [W-1:0] mplier_i,
    input  wire logic         mcand_signed_i,
    input  wire logic         mplier_signed_i,
    // product
    output logic [2*W:0]      prod_o
);
    logic [2*W:0] ext_a;
    logic [2*W:0] acc;

    // ========================================================================
    // shift-and-add; a signed multiplier's top bit weighs negative, so its
    // partial product is the negated multiplicand
    always_comb begin
        ext_a = {{(W+1){mcand_signed_i & mcand_i[W-1]}}, mcand_i};
        acc   = '0;
        for (int i = 0; i < W; i++) begin
            if (mplier_i[i]) begin
                if (i == W-1 && mplier_signed_i) begin
                    acc = acc - (ext_a << i);
                end else begin
                    acc = acc + (ext_a << i);
                end
            end
        end
        prod_o = acc;
    end
endmodule

// File: logic/aac_core.sv
// Summary of operation
// - products sign-extend to fill the accumulator
// - fraction bit set shifts products left once
// - signed multiplier top bit subtracts the multiplicand
// - add, subtract and shift ops update carry
// - carry taken at bit 31, or 39 wide
// - software may write the carry directly
// - saturation off lets results wrap
// - double-word ops use both buses, one cycle
// - each multiply operand signed or unsigned
// - carry lives in status register zero
// - accumulator additions set carry on carry-out
// - memory plus memory or immediate sets carry
// - additions without carry clear the flag
// - high-half add may only set carry
// - add with carry uses zero-extended operand
// - subtraction borrow clears the carry
// - subtraction without borrow sets the carry
// - high-half subtract may only clear carry
// - borrow is the inverse of carry
// - subtract with borrow uses zero-extended operand
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ns
module aac_core
    import aac_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // apb slave
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // status
    output logic             carry_o
);
    import aac_pkg::*;

    logic [AAC_ACC_W-1:0] acc [2];
    logic [4:0]           status_reg_one;
    logic                 carry;
    logic [AAC_BUS_W-1:0] read_bus_c;
    logic [AAC_BUS_W-1:0] read_bus_d;
    logic [AAC_BUS_W-1:0] imm;
    logic [9:0]           cmd;
    logic                 setup;
    logic                 xfer;
    logic                 wr_en;
    logic                 mapped;
    logic [31:0]          next_prdata;
    logic                 product_frac_shift;
    logic                 alu_saturate_mode;
    logic                 wide_carry_mode;
    logic                 exec;
    aac_op_type           op;
    logic                 src;
    logic                 dst;
    logic [AAC_ACC_W-1:0] accum_src;
    logic [AAC_ACC_W-1:0] accum_dst;
    logic [2*AAC_BUS_W:0] prod;
    logic [AAC_ACC_W-1:0] opa;
    logic [AAC_ACC_W-1:0] opb;
    logic [AAC_ACC_W-1:0] bx;
    logic                 sub;
    logic                 cin;
    logic                 use_sum;
    logic [AAC_ACC_W:0]   sum41;
    logic [32:0]          sum33;
    logic                 cout;
    logic                 ovf;
    aac_cmode_type        cmode;
    logic                 write_res;
    logic [AAC_ACC_W-1:0] shres;
    logic                 shcy;
    logic [AAC_ACC_W-1:0] next_res;
    logic                 next_carry;

    // ========================================================================
    // apb slave: answer in the first access cycle
    assign setup  = psel_i & ~penable_i;
    assign xfer   = psel_i & penable_i & pready_o;
    assign wr_en  = xfer & pwrite_i & ~pslverr_o;
    assign product_frac_shift = status_reg_one[AAC_FRAC_BIT];
    assign alu_saturate_mode  = status_reg_one[AAC_SAT_BIT];
    assign wide_carry_mode    = status_reg_one[AAC_WIDE_BIT];

    always_comb begin
        mapped      = 1'b1;
        next_prdata = '0;
        unique case (paddr_i)
            AAC_STATUS1_OFF: next_prdata = {27'h0, status_reg_one};
            AAC_STATUS0_OFF: next_prdata = {31'h0, carry};
            AAC_BUSC_OFF:    next_prdata = {16'h0, read_bus_c};
            AAC_BUSD_OFF:    next_prdata = {16'h0, read_bus_d};
            AAC_IMM_OFF:     next_prdata = {16'h0, imm};
            AAC_CMD_OFF:     next_prdata = {22'h0, cmd};
            AAC_ACC0_LO_OFF: next_prdata = acc[0][31:0];
            AAC_ACC0_HI_OFF: next_prdata = {24'h0, acc[0][39:32]};
            AAC_ACC1_LO_OFF: next_prdata = acc[1][31:0];
            AAC_ACC1_HI_OFF: next_prdata = {24'h0, acc[1][39:32]};
            default:         mapped = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup & ~mapped;
            if (setup) begin
                prdata_o <= next_prdata;
            end
        end
    end

    // ========================================================================
    // mode, operand and command registers
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_reg_one <= AAC_STATUS1_RST;
            read_bus_c     <= '0;
            read_bus_d     <= '0;
            imm            <= '0;
            cmd            <= '0;
        end else if (wr_en) begin
            unique case (paddr_i)
                AAC_STATUS1_OFF: status_reg_one <= pwdata_i[4:0];
                AAC_BUSC_OFF:    read_bus_c     <= pwdata_i[15:0];
                AAC_BUSD_OFF:    read_bus_d     <= pwdata_i[15:0];
                AAC_IMM_OFF:     imm            <= pwdata_i[15:0];
                AAC_CMD_OFF:     cmd            <= pwdata_i[9:0];
                default:         ;
            endcase
        end
    end

    // a command executes at the very edge that completes its write
    assign exec      = wr_en & (paddr_i == AAC_CMD_OFF);
    assign op        = aac_op_type'(pwdata_i[4:0]);
    assign src       = pwdata_i[AAC_CMD_SRC];
    assign dst       = pwdata_i[AAC_CMD_DST];
    assign accum_src = acc[src];
    assign accum_dst = acc[dst];

    // ========================================================================
    // multiplier: bus c times bus d
    aac_mult #(
        .W (AAC_BUS_W)
    ) u_mult (
        .mcand_i         (read_bus_c),
        .mplier_i        (read_bus_d),
        .mcand_signed_i  (status_reg_one[AAC_SGNC_BIT]),
        .mplier_signed_i (status_reg_one[AAC_SGND_BIT]),
        .prod_o          (prod)
    );

    // ========================================================================
    // operand selection; memory and immediate operands sign-extend, except bus c in add with carry and subtract with borrow
    always_comb begin
        opa       = accum_src;
        opb       = '0;
        sub       = 1'b0;
        cin       = 1'b0;
        use_sum   = 1'b1;
        write_res = 1'b1;
        cmode     = AAC_CM_ALL;
        unique case (op)
            AAC_ADD_ACC:  opb = accum_dst;
            AAC_ADD_MEM:  opb = {{24{read_bus_c[15]}}, read_bus_c};
            AAC_ADD_IMM:  opb = {{24{imm[15]}}, imm};
            AAC_ADD_MM: begin
                opa = {{24{read_bus_c[15]}}, read_bus_c};
                opb = {{24{read_bus_d[15]}}, read_bus_d};
            end
            AAC_ADD_MI: begin
                opa = {{24{read_bus_c[15]}}, read_bus_c};
                opb = {{24{imm[15]}}, imm};
            end
            AAC_ADD_HI16: begin
                opb   = {{8{read_bus_c[15]}}, read_bus_c, 16'h0};
                cmode = AAC_CM_SET;
            end
            AAC_ADD_CY: begin
                opb = {24'h0, read_bus_c};
                cin = carry;
            end
            AAC_ADD_DBL:  opb = {{8{read_bus_c[15]}}, read_bus_c, read_bus_d};
            AAC_LD_DBL: begin
                opa   = '0;
                opb   = {{8{read_bus_c[15]}}, read_bus_c, read_bus_d};
                cmode = AAC_CM_NONE;
            end
            AAC_SUB_ACC: begin
                opb = accum_dst;
                sub = 1'b1;
                cin = 1'b1;
            end
            AAC_SUB_MEM: begin
                opb = {{24{read_bus_c[15]}}, read_bus_c};
                sub = 1'b1;
                cin = 1'b1;
            end
            AAC_SUB_IMM: begin
                opb = {{24{imm[15]}}, imm};
                sub = 1'b1;
                cin = 1'b1;
            end
            AAC_SUB_MM: begin
                opa = {{24{read_bus_c[15]}}, read_bus_c};
                opb = {{24{read_bus_d[15]}}, read_bus_d};
                sub = 1'b1;
                cin = 1'b1;
            end
            AAC_SUB_MI: begin
                opa = {{24{read_bus_c[15]}}, read_bus_c};
                opb = {{24{imm[15]}}, imm};
                sub = 1'b1;
                cin = 1'b1;
            end
            AAC_SUB_HI16: begin
                opb   = {{8{read_bus_c[15]}}, read_bus_c, 16'h0};
                sub   = 1'b1;
                cin   = 1'b1;
                cmode = AAC_CM_CLR;
            end
            AAC_SUB_BW: begin
                // a - b - borrow equals a + ~b + carry since borrow is ~carry
                opb = {24'h0, read_bus_c};
                sub = 1'b1;
                cin = carry;
            end
            AAC_SUB_DBL: begin
                opb = {{8{read_bus_c[15]}}, read_bus_c, read_bus_d};
                sub = 1'b1;
                cin = 1'b1;
            end
            AAC_MPY: begin
                use_sum = 1'b0;
                cmode   = AAC_CM_NONE;
            end
            AAC_SHL1, AAC_SHR1: use_sum = 1'b0;
            AAC_CSET: begin
                write_res = 1'b0;
                cmode     = AAC_CM_ONE;
            end
            AAC_CCLR: begin
                write_res = 1'b0;
                cmode     = AAC_CM_ZERO;
            end
            default: begin
                write_res = 1'b0;
                cmode     = AAC_CM_NONE;
            end
        endcase
    end

    // ========================================================================
    // adder with carry detection at bit 31 or bit 39
    assign bx    = sub ? ~opb : opb;
    assign sum41 = {1'b0, opa} + {1'b0, bx} + {40'h0, cin};
    assign sum33 = {1'b0, opa[31:0]} + {1'b0, bx[31:0]} + {32'h0, cin};
    assign cout  = wide_carry_mode ? sum41[40] : sum33[32];
    assign ovf   = wide_carry_mode ?
                   ((opa[39] == bx[39]) && (sum41[39] != opa[39])) :
                   !((&sum41[39:31]) || !(|sum41[39:31]));

    // right shifts and wide left shifts move the outgoing bit into carry; a narrow left shift takes bit 31
    always_comb begin
        if (op == AAC_SHL1) begin
            shres = {accum_src[38:0], 1'b0};
            shcy  = wide_carry_mode ? accum_src[39] : accum_src[31];
        end else begin
            shres = {accum_src[39], accum_src[39:1]};
            shcy  = accum_src[0];
        end
    end

    // ========================================================================
    // result: saturate only when asked, otherwise wrap
    always_comb begin
        if (use_sum) begin
            if (alu_saturate_mode && ovf) begin
                if (wide_carry_mode) begin
                    // a wide overflow flips the sign bit, so a set bit means the true sum was positive
                    next_res = sum41[39] ? 40'h7fffffffff : 40'h8000000000;
                end else begin
                    next_res = sum41[39] ? 40'hff80000000 : 40'h007fffffff;
                end
            end else begin
                next_res = sum41[39:0];
            end
        end else if (op == AAC_MPY) begin
            // 33-bit product sign-extends over the guard bits
            if (product_frac_shift) begin
                next_res = {{6{prod[32]}}, prod, 1'b0};
            end else begin
                next_res = {{7{prod[32]}}, prod};
            end
        end else begin
            next_res = shres;
        end
    end

    always_comb begin
        unique case (cmode)
            AAC_CM_ALL:  next_carry = use_sum ? cout : shcy;
            AAC_CM_SET:  next_carry = carry | cout;
            AAC_CM_CLR:  next_carry = carry & cout;
            AAC_CM_ONE:  next_carry = 1'b1;
            AAC_CM_ZERO: next_carry = 1'b0;
            default:     next_carry = carry;
        endcase
    end

    // ========================================================================
    // accumulators and carry
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc[0] <= '0;
            acc[1] <= '0;
        end else if (exec && write_res) begin
            acc[dst] <= next_res;
        end else if (wr_en) begin
            unique case (paddr_i)
                AAC_ACC0_LO_OFF: acc[0][31:0]  <= pwdata_i;
                AAC_ACC0_HI_OFF: acc[0][39:32] <= pwdata_i[7:0];
                AAC_ACC1_LO_OFF: acc[1][31:0]  <= pwdata_i;
                AAC_ACC1_HI_OFF: acc[1][39:32] <= pwdata_i[7:0];
                default:         ;
            endcase
        end
    end

    // the carry flag is bit 0 of status register zero
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            carry <= AAC_CARRY_RST;
        end else if (exec) begin
            carry <= next_carry;
        end else if (wr_en && paddr_i == AAC_STATUS0_OFF) begin
            carry <= pwdata_i[AAC_CARRY_BIT];
        end
    end

    assign carry_o = carry;

    // ========================================================================
    // checks: helper state sampled at the executing edge
    logic                 done_q;
    aac_op_type           op_q;
    logic                 dst_q;
    logic                 wide_q;
    logic                 sat_q;
    logic                 frac_q;
    logic                 prev_cy_q;
    logic                 cout_q;
    logic [AAC_ACC_W-1:0] opa_q;
    logic [AAC_ACC_W-1:0] opb_q;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_q    <= 1'b0;
            op_q      <= AAC_NOP;
            dst_q     <= 1'b0;
            wide_q    <= 1'b0;
            sat_q     <= 1'b0;
            frac_q    <= 1'b0;
            prev_cy_q <= 1'b0;
            cout_q    <= 1'b0;
            opa_q     <= '0;
            opb_q     <= '0;
        end else begin
            done_q    <= exec;
            op_q      <= op;
            dst_q     <= dst;
            wide_q    <= wide_carry_mode;
            sat_q     <= alu_saturate_mode;
            frac_q    <= product_frac_shift;
            prev_cy_q <= carry;
            cout_q    <= cout;
            opa_q     <= opa;
            opb_q     <= opb;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_apb_setup;
        psel_i && !penable_i;
    endsequence

    sequence s_ready_once;
        pready_o ##1 !pready_o;
    endsequence

    a_apb_one_wait: assert property (s_apb_setup ##1 penable_i |-> s_ready_once)
        else $error("apb answer not a single ready cycle");

    a_hi16_add_set: assert property (done_q && op_q == AAC_ADD_HI16 |->
        carry_o == (prev_cy_q | cout_q))
        else $error("high-half add cleared carry");

    a_hi16_sub_clr: assert property (done_q && op_q == AAC_SUB_HI16 |->
        carry_o == (prev_cy_q & cout_q))
        else $error("high-half subtract set carry");

    a_sub_no_borrow: assert property (done_q && op_q == AAC_SUB_MEM && !wide_q |->
        carry_o == (opa_q[31:0] >= opb_q[31:0]))
        else $error("subtract carry not inverse of borrow");

    a_wide_add_carry: assert property (done_q && op_q == AAC_ADD_ACC && wide_q |->
        carry_o == (40'(opa_q + opb_q) < opa_q))
        else $error("carry not taken at bit 39");

    a_borrow_inverse: assert property (done_q && op_q == AAC_SUB_BW && !wide_q |->
        carry_o == ({1'b0, opa_q[31:0]} >= {1'b0, opb_q[31:0]} + {32'h0, !prev_cy_q}))
        else $error("borrow not taken as inverse carry");

    a_wrap_nosat: assert property (done_q && op_q == AAC_ADD_ACC && !sat_q |->
        acc[dst_q] == 40'(opa_q + opb_q))
        else $error("result did not wrap");

    a_frac_shift: assert property (done_q && op_q == AAC_MPY && frac_q |->
        acc[dst_q][0] == 1'b0 && acc[dst_q][39] == acc[dst_q][33])
        else $error("fractional product not shifted");

    a_mpy_sign_ext: assert property (done_q && op_q == AAC_MPY && !frac_q |->
        (&acc[dst_q][39:32]) || !(|acc[dst_q][39:32]))
        else $error("product not sign extended");

    a_carry_write: assert property (wr_en && paddr_i == AAC_STATUS0_OFF |=>
        carry_o == $past(pwdata_i[0]) ##1 carry_o == $past(carry_o))
        else $error("carry write lost");
endmodule

// File: tb/aac_apb_master.sv
`timescale 1ns/1ns
// ============================================================================
// operand fetch stand-in: drives the apb side, one transfer at a time
module aac_apb_master (
    // clock
    input  wire logic        mclk_i,
    // apb answer
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    input  wire logic [31:0] prdata_i,
    // apb request
    output logic [7:0]       paddr_o,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [31:0]      pwdata_o,
    output logic             hang_o
);
    initial begin
        paddr_o = 8'h00;
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        pwdata_o = 32'h0;
        hang_o = 1'b0;
    end

    // request held until the edge that sees pready; data taken at that edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel_o <= 1'b1;
        paddr_o <= a;
        pwrite_o <= w;
        pwdata_o <= d;
        @(posedge mclk_i);
        penable_o <= 1'b1;
        @(posedge mclk_i);
        while (pready_i !== 1'b1 && n < 16) begin
            @(posedge mclk_i);
            n++;
        end
        if (pready_i !== 1'b1) hang_o = 1'b1;
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // idle write data flips so a stale value is never mistaken for fresh
        pwdata_o <= ~d;
    endtask
endmodule

// File: tb/accumulator_alu_carry_logic_tb_top.sv
`timescale 1ns/1ns
module accumulator_alu_carry_logic_tb_top;
    import aac_pkg::*;
    logic mclk_i, nrst_i, psel, penable, pwrite, pready, pslverr, carry, hang;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int miscompares, n_tests;

    aac_core u_aac_core (.mclk_i(mclk_i), .nrst_i(nrst_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .carry_o(carry));
    aac_apb_master u_aac_apb_master (.mclk_i(mclk_i), .pready_i(pready), .pslverr_i(pslverr),
        .prdata_i(prdata), .paddr_o(paddr), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .pwdata_o(pwdata), .hang_o(hang));

    // ========================================================================
    // shared tasks
    task automatic finish_test;
        if (hang) miscompares++;
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [39:0] x, input logic [39:0] g);
        n_tests++;
        if (g !== x) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        u_aac_apb_master.xfer(1'b1, a, d, q, e);
        if (hang) finish_test;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
        u_aac_apb_master.xfer(1'b0, a, 32'h0, q, e);
        if (hang) finish_test;
    endtask
    task automatic set(input logic [39:0] a, input logic [15:0] c, input logic [15:0] d, input logic cy);
        wr(AAC_ACC0_LO_OFF, a[31:0]);
        wr(AAC_ACC0_HI_OFF, {24'h0, a[39:32]});
        wr(AAC_BUSC_OFF, {16'h0, c});
        wr(AAC_BUSD_OFF, {16'h0, d});
        wr(AAC_STATUS0_OFF, {31'h0, cy});
    endtask
    // command on acc0 into acc0; carry checked 1 ns after the completing edge
    task automatic run(input aac_op_type op, input logic [39:0] xa, input logic xc);
        logic [31:0] lo, hi;
        logic e;
        wr(AAC_CMD_OFF, {27'h0, op});
        #1;
        chk("carry", {39'h0, xc}, {39'h0, carry});
        rd(AAC_ACC0_LO_OFF, lo, e);
        rd(AAC_ACC0_HI_OFF, hi, e);
        chk("acc0", xa, {hi[7:0], lo});
    endtask

    // ========================================================================
    // scenarios
    task automatic t_reset;
        logic [31:0] q;
        logic e;
        rd(AAC_STATUS1_OFF, q, e);
        chk("status1", 40'h18, {8'h0, q});
        chk("carry", 40'h0, {39'h0, carry});
        rd(8'h28, q, e);
        chk("unmapped err", 40'h1, {39'h0, e});
        wr(AAC_STATUS0_OFF, 32'h1);
        rd(AAC_STATUS0_OFF, q, e);
        chk("status0", 40'h1, {8'h0, q});
    endtask
    task automatic t_add;
        set(40'h00_ffffffff, 16'h0001, 16'h0, 1'b0);
        run(AAC_ADD_MEM, 40'h01_00000000, 1'b1);
        run(AAC_ADD_MEM, 40'h01_00000001, 1'b0);
        set(40'h0, 16'hffff, 16'h0002, 1'b0);
        run(AAC_ADD_MM, 40'h00_00000001, 1'b1);
        set(40'h0, 16'h0001, 16'h0, 1'b1);
        run(AAC_ADD_HI16, 40'h00_00010000, 1'b1);
        set(40'h0, 16'hffff, 16'h0, 1'b1);
        run(AAC_ADD_CY, 40'h00_00010000, 1'b0);
        wr(AAC_STATUS1_OFF, 32'h1c);
        set(40'hff_ffffffff, 16'h0001, 16'h0, 1'b0);
        run(AAC_ADD_MEM, 40'h00_00000000, 1'b1);
        set(40'h7f_ffffffff, 16'h0001, 16'h0, 1'b1);
        run(AAC_ADD_MEM, 40'h80_00000000, 1'b0);
        run(AAC_ADD_ACC, 40'h00_00000000, 1'b1);
        // saturation on: wide clamps at 40 bits, narrow at 32 bits
        wr(AAC_STATUS1_OFF, 32'h1e);
        set(40'h7f_ffffffff, 16'h0001, 16'h0, 1'b0);
        run(AAC_ADD_MEM, 40'h7f_ffffffff, 1'b0);
        wr(AAC_STATUS1_OFF, 32'h1a);
        set(40'h00_7fffffff, 16'h0001, 16'h0, 1'b0);
        run(AAC_ADD_MEM, 40'h00_7fffffff, 1'b0);
        wr(AAC_STATUS1_OFF, 32'h18);
    endtask
    task automatic t_sub;
        set(40'h0, 16'h0001, 16'h0, 1'b1);
        run(AAC_SUB_MEM, 40'hff_ffffffff, 1'b0);
        set(40'h5, 16'h0004, 16'h0, 1'b0);
        run(AAC_SUB_MEM, 40'h00_00000001, 1'b1);
        set(40'h00_00010000, 16'h0001, 16'h0, 1'b0);
        run(AAC_SUB_HI16, 40'h0, 1'b0);
        set(40'h0, 16'h0001, 16'h0, 1'b1);
        run(AAC_SUB_HI16, 40'hff_ffff0000, 1'b0);
        set(40'h00_00010000, 16'hffff, 16'h0, 1'b0);
        run(AAC_SUB_BW, 40'h0, 1'b1);
    endtask
    task automatic t_dbl;
        set(40'hff_ffffffff, 16'h1234, 16'h5678, 1'b1);
        run(AAC_LD_DBL, 40'h00_12345678, 1'b1);
        run(AAC_ADD_DBL, 40'h00_2468acf0, 1'b0);
        run(AAC_CCLR, 40'h00_2468acf0, 1'b0);
        set(40'h00_80000001, 16'h0, 16'h0, 1'b0);
        run(AAC_SHL1, 40'h01_00000002, 1'b1);
        run(AAC_SHR1, 40'h00_80000001, 1'b0);
        wr(AAC_IMM_OFF, 32'h0000ffff);
        run(AAC_ADD_IMM, 40'h00_80000000, 1'b1);
    endtask
    task automatic t_mpy;
        set(40'h0, 16'h0004, 16'hfffd, 1'b0);
        run(AAC_MPY, 40'hff_fffffff4, 1'b0);
        wr(AAC_STATUS1_OFF, 32'h19);
        run(AAC_MPY, 40'hff_ffffffe8, 1'b0);
        wr(AAC_STATUS1_OFF, 32'h08);
        run(AAC_MPY, 40'h00_0003fff4, 1'b0);
    endtask

    // ========================================================================
    // clock, reset, sequence and watchdog
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    initial begin
        miscompares = 0;
        n_tests = 0;
        nrst_i = 1'b0;
        repeat (8) @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_reset;
        t_add;
        t_sub;
        t_dbl;
        t_mpy;
        finish_test;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        finish_test;
    end
endmodule
